/* File: rtl/sensor_serial_port.sv */
// Serial register port of the motion sensor and its register file.
// The host serial clock runs the link logic; clk runs the register file.
// The serial clock stops between frames, so the link side never relies
// on an edge after a frame; the power-down pin clears it asynchronously.
`timescale 1ns/100ps
`default_nettype none

module sensor_serial_port #(
    parameter int         NUM_REGS = sensor_serial_pkg::NUM_REGS_DEFAULT,
    parameter logic [7:0] ID_VALUE = 8'h5a  // Arbitrary identity value
) (
    input  wire logic                             clk,
    input  wire logic                             rst,
    input  wire logic                             sclk,
    input  wire logic                             power_down_pin,
    input  wire logic                             sdio_in,
    output logic                                  sdio_out,
    output logic                                  sdio_oe,
    input  wire sensor_serial_pkg::reg_write_type core_wr,
    input  wire logic [6:0]                       core_rd_addr,
    output logic [7:0]                            core_rd_data,
    output sensor_serial_pkg::reg_write_type      host_wr,
    output sensor_serial_pkg::reg_read_type       host_rd,
    output logic                                  host_abort,
    output logic                                  shutdown
);

    localparam int AW = sensor_serial_pkg::ADDR_W;
    localparam int DW = sensor_serial_pkg::DATA_W;
    localparam int CW = sensor_serial_pkg::CNT_W;

    // Link-side state (sclk domain)
    sensor_serial_pkg::link_phase_type phase_r;
    logic [CW-1:0]                     bit_cnt_r;
    logic [DW-1:0]                     shift_r;
    logic [DW-1:0]                     hdr_r;
    logic                              rd_phase_r;
    logic                              busy_r;
    logic                              sdo_oe_r;
    logic [DW-1:0]                     sdo_shift_r;
    logic                              wr_tgl_r;
    logic                              rd_tgl_r;
    logic [AW-1:0]                     wr_addr_r;
    logic [DW-1:0]                     wr_data_r;
    logic [AW-1:0]                     rd_addr_r;
    logic                              link_rst;
    logic [DW-1:0]                     rx_byte;
    logic [DW-1:0]                     snap_byte;

    // Register side state (clk domain)
    logic [DW-1:0]                     regs_r [NUM_REGS];
    logic [DW-1:0]                     snap_r [NUM_REGS];
    logic                              pd_sync;
    logic                              busy_sync;
    logic                              wr_tgl_sync;
    logic                              rd_tgl_sync;
    logic                              wr_tgl_prev_r;
    logic                              rd_tgl_prev_r;
    logic                              pd_prev_r;
    logic                              busy_prev_r;
    logic                              wr_evt;
    logic                              rd_evt;

    // Power-down clears only the serial port, never the registers
    // The host holds sclk still while the pin falls, so release is clean
    assign link_rst = rst | power_down_pin;

    // Byte as it stands once the current bit is shifted in, MSB first
    assign rx_byte = {shift_r[DW-2:0], sdio_in};

    // Byte of the frozen copy at the captured address; a hole reads zero
    always_comb begin
        snap_byte = sensor_serial_pkg::REG_RESET;
        if (int'(hdr_r[AW-1:0]) < NUM_REGS) begin
            snap_byte = snap_r[hdr_r[AW-1:0]];
        end
    end

    // Frame sequencer: every rising edge samples one bit; the host alone
    // opens a frame with its first clock, the sensor never does
    always_ff @(posedge sclk or posedge link_rst) begin
        if (link_rst) begin
            phase_r    <= sensor_serial_pkg::LINK_IDLE;
            bit_cnt_r  <= '0;
            shift_r    <= '0;
            hdr_r      <= '0;
            rd_phase_r <= 1'b0;
        end else begin
            shift_r <= rx_byte;
            case (phase_r)
                sensor_serial_pkg::LINK_IDLE: begin
                    // First rising edge of a frame carries the direction
                    phase_r   <= sensor_serial_pkg::LINK_ADDR;
                    bit_cnt_r <= sensor_serial_pkg::CNT_FIRST;
                end
                sensor_serial_pkg::LINK_ADDR: begin
                    bit_cnt_r <= bit_cnt_r + CW'(1);
                    if (bit_cnt_r == sensor_serial_pkg::CNT_ADDR_LAST) begin
                        // Header complete: bit 7 direction, low bits address
                        hdr_r   <= rx_byte;
                        phase_r <= sensor_serial_pkg::LINK_DATA;
                        rd_phase_r <= (rx_byte[sensor_serial_pkg::DIR_BIT]
                                       == sensor_serial_pkg::DIR_READ);
                    end
                end
                sensor_serial_pkg::LINK_DATA: begin
                    bit_cnt_r <= bit_cnt_r + CW'(1);
                    if (bit_cnt_r == sensor_serial_pkg::CNT_DATA_LAST) begin
                        // Second byte done: frame is exactly two bytes
                        phase_r    <= sensor_serial_pkg::LINK_IDLE;
                        bit_cnt_r  <= '0;
                        rd_phase_r <= 1'b0;
                    end
                end
                default: begin
                    phase_r   <= sensor_serial_pkg::LINK_IDLE;
                    bit_cnt_r <= '0;
                end
            endcase
        end
    end

    // Busy level for the register side; a flop so the crossing is clean.
    // It drops on the last rising edge, the final edge of the frame.
    always_ff @(posedge sclk or posedge link_rst) begin
        if (link_rst) begin
            busy_r <= 1'b0;
        end else if (phase_r == sensor_serial_pkg::LINK_DATA &&
                     bit_cnt_r == sensor_serial_pkg::CNT_DATA_LAST) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= 1'b1;
        end
    end

    // Completed write: address and data load on the same edge the toggle flips.
    // Reset by rst only, so power-down cannot fake a toggle; an aborted
    // frame never reaches this edge and writes nothing.
    // A toggle, not a pulse: sclk may stop after this edge, so a pulse
    // could never be taken down again.
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            wr_tgl_r  <= 1'b0;
            wr_addr_r <= '0;
            wr_data_r <= '0;
        end else if (!power_down_pin &&
                     phase_r == sensor_serial_pkg::LINK_DATA &&
                     bit_cnt_r == sensor_serial_pkg::CNT_DATA_LAST &&
                     hdr_r[sensor_serial_pkg::DIR_BIT] ==
                     sensor_serial_pkg::DIR_WRITE) begin
            wr_addr_r <= hdr_r[AW-1:0];
            wr_data_r <= rx_byte;
            wr_tgl_r  <= ~wr_tgl_r;
        end
    end

    // Completed read, reported to the core side the same way
    // Nothing on the core side waits for it; it only feeds the report
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            rd_tgl_r  <= 1'b0;
            rd_addr_r <= '0;
        end else if (!power_down_pin &&
                     phase_r == sensor_serial_pkg::LINK_DATA &&
                     bit_cnt_r == sensor_serial_pkg::CNT_DATA_LAST &&
                     hdr_r[sensor_serial_pkg::DIR_BIT] ==
                     sensor_serial_pkg::DIR_READ) begin
            rd_addr_r <= hdr_r[AW-1:0];
            rd_tgl_r  <= ~rd_tgl_r;
        end
    end

    // Read data driver on falling edges. The first fall after the header
    // loads the byte and turns the driver on; later falls shift it out.
    // The frozen copy is steady here, so reading it across is safe.
    always_ff @(negedge sclk or posedge link_rst) begin
        if (link_rst) begin
            sdo_oe_r    <= 1'b0;
            sdo_shift_r <= '0;
        end else begin
            sdo_oe_r <= rd_phase_r;
            if (!sdo_oe_r) begin
                sdo_shift_r <= snap_byte;
            end else begin
                sdo_shift_r <= {sdo_shift_r[DW-2:0], 1'b0};
            end
        end
    end

    // Pin drive: on only while both edges agree we are in the read data
    // phase. The rising edge that samples the last bit ends the phase and
    // releases the pin at once; a write never turns it on.
    assign sdio_oe  = sdo_oe_r & rd_phase_r;
    assign sdio_out = sdo_shift_r[DW-1];

    // Crossings into the clk domain
    // Every bit is a level or a toggle, so bits may arrive a cycle apart
    sync_2ff #(
        .WIDTH(4)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({power_down_pin, busy_r, wr_tgl_r, rd_tgl_r}),
        .q   ({pd_sync, busy_sync, wr_tgl_sync, rd_tgl_sync})
    );

    // Write toggle one cycle back; reset matches the synchroniser, so
    // no false event follows reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_tgl_prev_r <= 1'b0;
        end else begin
            wr_tgl_prev_r <= wr_tgl_sync;
        end
    end

    // Read toggle one cycle back
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_tgl_prev_r <= 1'b0;
        end else begin
            rd_tgl_prev_r <= rd_tgl_sync;
        end
    end

    // Power-down level one cycle back, for its rising edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pd_prev_r <= 1'b0;
        end else begin
            pd_prev_r <= pd_sync;
        end
    end

    // Busy one cycle back. Power-down clears the busy flop the moment
    // the pin rises, so both changes arrive here together; the abort
    // test must see busy as it stood before the pin rose.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_prev_r <= 1'b0;
        end else begin
            busy_prev_r <= busy_sync;
        end
    end

    assign wr_evt = wr_tgl_sync ^ wr_tgl_prev_r;
    assign rd_evt = rd_tgl_sync ^ rd_tgl_prev_r;

    // Shutdown level follows the pin for as long as it stays high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shutdown <= 1'b0;
        end else begin
            shutdown <= pd_sync;
        end
    end

    // Abort report: power-down rose while a frame was open
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            host_abort <= 1'b0;
        end else begin
            host_abort <= pd_sync & ~pd_prev_r &
                          (busy_sync | busy_prev_r);
        end
    end

    // Register file. A host write wins over a core write to the same
    // register in the same cycle; the core value is then lost, which is
    // the trade for a single write port per register.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_r[i] <= sensor_serial_pkg::REG_RESET;
            end
            regs_r[sensor_serial_pkg::ID_REG_ADDR] <= ID_VALUE;
        end else begin
            for (int i = 0; i < NUM_REGS; i++) begin
                if (wr_evt && wr_addr_r == AW'(i)) begin
                    regs_r[i] <= wr_data_r;
                end else if (core_wr.valid && core_wr.addr == AW'(i)) begin
                    regs_r[i] <= core_wr.data;
                end
            end
        end
    end

    // Frozen copy for the link. It tracks the file while no frame is open
    // and holds still during a frame, so motion updates cannot tear a
    // read. A host write also lands here at once, so a read-back that
    // follows straight after a write still returns the new value.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                snap_r[i] <= sensor_serial_pkg::REG_RESET;
            end
            snap_r[sensor_serial_pkg::ID_REG_ADDR] <= ID_VALUE;
        end else begin
            for (int i = 0; i < NUM_REGS; i++) begin
                if (wr_evt && wr_addr_r == AW'(i)) begin
                    snap_r[i] <= wr_data_r;
                end else if (!busy_sync) begin
                    snap_r[i] <= regs_r[i];
                end
            end
        end
    end

    // Core read port, one cycle of latency
    // Addresses past the file read zero rather than alias a register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            core_rd_data <= sensor_serial_pkg::REG_RESET;
        end else if (int'(core_rd_addr) < NUM_REGS) begin
            core_rd_data <= regs_r[core_rd_addr];
        end else begin
            core_rd_data <= sensor_serial_pkg::REG_RESET;
        end
    end

    // Host write report, one clk cycle; address and data stand still
    // on the link side from the toggle on, so the copy here is whole
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            host_wr <= '0;
        end else begin
            host_wr.valid <= wr_evt;
            host_wr.addr  <= wr_addr_r;
            host_wr.data  <= wr_data_r;
        end
    end

    // Host read report, one clk cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            host_rd <= '0;
        end else begin
            host_rd.valid <= rd_evt;
            host_rd.addr  <= rd_addr_r;
        end
    end

endmodule

`default_nettype wire

/* File: rtl/sensor_serial_pkg.sv */
// Constants, field layouts and carrier types of the sensor serial port.
// Assumes one register file clock (clk) and one link clock (the host serial clock).
// How it works
// - Only the host starts a transfer; the sensor never starts one.
// - The driving party changes the data line only after a falling edge.
// - A transfer is two bytes: direction bit 7 plus address, then data.
// - Direction 1 means write; the host data byte lands in the register.
// - During a write the sensor samples the line on rising clock edges.
// - Direction 0 means read; the sensor drives the returned data byte.
// - On a read the sensor drives only from the fall after the address.
// - The sensor releases the line on the rising edge after the last bit.
// - The sensor drives the line only in the data phase of a read.
// - After a read the last data bit stays until a rising edge.
// - Power-down high plus a clock high-low-high leaves the line released.
// - Power-down aborts a transfer, writes nothing, resets only the port.
// - While power-down is high the sensor stays shut down.

package sensor_serial_pkg;

    // Field layout of a transfer
    localparam int ADDR_W    = 7;
    localparam int DATA_W    = 8;
    localparam int DIR_BIT   = 7;
    localparam int CNT_W     = 5;
    localparam logic DIR_WRITE = 1'b1;
    localparam logic DIR_READ  = 1'b0;

    // Bit counter values after the first bit, at the last address bit and the last data bit
    localparam logic [4:0] CNT_FIRST     = 5'h01;
    localparam logic [4:0] CNT_ADDR_LAST = 5'h07;
    localparam logic [4:0] CNT_DATA_LAST = 5'h0f;

    // Register file layout and reset values
    localparam int          NUM_REGS_DEFAULT = 128;
    localparam logic [6:0]  ID_REG_ADDR      = 7'h00;
    localparam logic [7:0]  REG_RESET        = 8'h00;

    // Timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int PD_PULSE_MIN_NS = 1000;
    localparam int PD_PULSE_MIN_CYCLES =
        (PD_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Phase of the serial frame, one-hot
    typedef enum logic [2:0] {
        LINK_IDLE = 3'b001,
        LINK_ADDR = 3'b010,
        LINK_DATA = 3'b100
    } link_phase_type;

    // One register write: from the core, or reported from the host
    typedef struct packed {
        logic       valid;
        logic [6:0] addr;
        logic [7:0] data;
    } reg_write_type;

    // One completed host read, reported to the core
    typedef struct packed {
        logic       valid;
        logic [6:0] addr;
    } reg_read_type;

endpackage

/* File: rtl/sync_2ff.sv */
// Two-flop level synchroniser, one per crossing signal bit.
// Assumes the input is steady for at least two destination clocks.
`timescale 1ns/100ps
`default_nettype none

module sync_2ff #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

`default_nettype wire

/* File: tb/sensor_serial_port_props.sv */
// Checker for the sensor serial port, bound to its top ports.
// Assumes sclk idles high and stands still between frames.
`timescale 1ns/100ps
`default_nettype none

module sensor_serial_port_props (
    input wire logic                             clk,
    input wire logic                             rst,
    input wire logic                             sclk,
    input wire logic                             power_down_pin,
    input wire logic                             sdio_in,
    input wire logic                             sdio_out,
    input wire logic                             sdio_oe,
    input wire sensor_serial_pkg::reg_write_type host_wr,
    input wire sensor_serial_pkg::reg_read_type  host_rd,
    input wire logic                             host_abort,
    input wire logic                             shutdown
);
    logic [3:0] cnt_r;
    logic [7:0] sh_r;
    logic [7:0] hdr_r;
    logic [7:0] dat_r;
    logic       hi_r;

    // Rises seen in the open frame; power-down drops the frame at once
    always_ff @(posedge sclk or posedge rst or posedge power_down_pin) begin
        if (rst || power_down_pin) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

    // Bytes as the sensor should have sampled them, and the driven bit
    always_ff @(posedge sclk) begin
        sh_r <= {sh_r[6:0], sdio_in};
        hi_r <= sdio_out;
        if (cnt_r == 4'h7) hdr_r <= {sh_r[6:0], sdio_in};
        if (cnt_r == 4'hf) dat_r <= {sh_r[6:0], sdio_in};
    end

    chk_addr_quiet: assert property (@(posedge sclk)
        disable iff (rst || power_down_pin) cnt_r < 4'h8 |-> !sdio_oe)
        else $error("sensor drove line in header byte");
    chk_read_drives: assert property (@(posedge sclk)
        disable iff (rst || power_down_pin)
        (cnt_r >= 4'h8 && !hdr_r[7]) |-> sdio_oe)
        else $error("sensor not driving read data");
    chk_drive_only_read: assert property (@(posedge clk)
        disable iff (rst) sdio_oe |-> (cnt_r >= 4'h8 && !hdr_r[7]))
        else $error("sensor drove line outside read data");
    chk_out_on_fall: assert property (@(negedge sclk)
        disable iff (rst) sdio_oe |-> sdio_out == hi_r)
        else $error("sensor data changed while clock high");
    chk_write_report: assert property (@(posedge clk)
        disable iff (rst)
        host_wr.valid |-> (host_wr == {1'b1, hdr_r[6:0], dat_r}) && hdr_r[7])
        else $error("host write report wrong");
    chk_write_pulse: assert property (@(posedge clk)
        disable iff (rst) host_wr.valid |=> !host_wr.valid)
        else $error("host write pulse too long");
    chk_read_report: assert property (@(posedge clk)
        disable iff (rst)
        host_rd.valid |-> host_rd.addr == hdr_r[6:0] && !hdr_r[7])
        else $error("host read report wrong");
    chk_abort_quiet: assert property (@(posedge clk)
        disable iff (rst) host_abort |-> (!host_wr.valid) [*6])
        else $error("register written after abort");
    chk_shutdown_on: assert property (@(posedge clk)
        disable iff (rst) $rose(power_down_pin) |-> ##[2:4] shutdown)
        else $error("shutdown not entered");
    chk_shutdown_off: assert property (@(posedge clk)
        disable iff (rst) $fell(power_down_pin) |-> ##[2:4] !shutdown)
        else $error("shutdown not left");
endmodule

bind sensor_serial_port sensor_serial_port_props i_props (
    .clk(clk), .rst(rst), .sclk(sclk), .power_down_pin(power_down_pin),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .host_wr(host_wr), .host_rd(host_rd), .host_abort(host_abort),
    .shutdown(shutdown)
);
`default_nettype wire

/* File: tb/host_model.sv */
// Host micro-controller model: makes sclk and drives the data line.
// Assumes frames are started from the testbench through its tasks.
`timescale 1ns/100ps
`default_nettype none

module host_model (
    input  wire logic clk,
    input  wire logic sdio_out,
    input  wire logic sdio_oe,
    output logic      sclk,
    output logic      sdio_in
);
    logic hoe = 1'b1;
    logic hd = 1'b1;
    logic flt_r = 1'b0;

    initial sclk = 1'b1;  // Clock stands high between frames

    // Undriven line wanders, so a stale bit never passes for data
    always @(posedge clk) flt_r <= ~flt_r;

    // Resolved level of the data line
    assign sdio_in = sdio_oe ? sdio_out : (hoe ? hd : flt_r);

    // One frame cut after n rises; header then data, MSB first
    task automatic frame(input logic [7:0] hdr, input logic [7:0] wd,
                         input int n, output logic [7:0] rd);
        logic [15:0] bits;
        bits = {hdr, wd};
        rd = 8'h00;
        hoe = 1'b1;  // Only the host opens a frame
        for (int i = 0; i < n; i++) begin
            if (i == 8 && !hdr[7]) hoe = 1'b0;  // Let go before fall
            sclk = 1'b0;
            hd = bits[15-i];  // New bit after the fall
            #7.5;
            if (i >= 8) rd = {rd[6:0], sdio_in};
            sclk = 1'b1;
            #7.5;
        end
        if (n == 16) hoe = 1'b1;  // Line is ours again
    endtask

    // High-low-high on sclk used to settle the line
    task automatic toggle;
        sclk = 1'b0;
        #7.5;
        sclk = 1'b1;
        #7.5;
    endtask
endmodule
`default_nettype wire

/* File: tb/sensor_serial_port_tb.sv */
// Self-checking testbench of the sensor serial port.
// Assumes host_model drives the link and the checker is bound in.
`timescale 1ns/100ps
`default_nettype none

module sensor_serial_port_tb;
    localparam logic [7:0] ID_VAL = 8'h3c;  // Arbitrary identity value
    logic       clk = 1'b0;
    logic       rst = 1'b0;
    logic       pd = 1'b0;
    logic       sclk;
    logic       sdio_in;
    logic       sdio_out;
    logic       sdio_oe;
    logic       host_abort;
    logic       shutdown;
    logic [6:0] core_rd_addr = 7'h00;
    logic [7:0] core_rd_data;
    logic [7:0] rd;
    sensor_serial_pkg::reg_write_type core_wr = '0;
    sensor_serial_pkg::reg_write_type host_wr;
    sensor_serial_pkg::reg_read_type  host_rd;
    int fails = 0;
    int checks_done = 0;
    int aborts = 0;
    int cyc = 0;

    always #5 clk = ~clk;

    sensor_serial_port #(.ID_VALUE(ID_VAL)) i_sensor_serial_port (
        .clk(clk), .rst(rst), .sclk(sclk), .power_down_pin(pd),
        .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .core_wr(core_wr), .core_rd_addr(core_rd_addr),
        .core_rd_data(core_rd_data), .host_wr(host_wr), .host_rd(host_rd),
        .host_abort(host_abort), .shutdown(shutdown)
    );

    host_model i_host_model (
        .clk(clk), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .sclk(sclk), .sdio_in(sdio_in)
    );

    // Abort pulses and a hang limit, read away from the launching edge
    always @(negedge clk) begin
        cyc++;
        if (host_abort === 1'b1) aborts++;
        if (cyc == 5000) begin
            fails++;
            finish_test();
        end
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp,
                        input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Register value through the core port, read two clocks after the address
    task automatic core_read(input logic [6:0] a, output logic [7:0] d);
        @(negedge clk) core_rd_addr = a;
        repeat (2) @(negedge clk);
        d = core_rd_data;
    endtask

    // Power-down pulse kept above the minimum width
    task automatic pd_pulse;
        repeat (sensor_serial_pkg::PD_PULSE_MIN_CYCLES + 10) @(negedge clk);
        cmp8({7'h00, shutdown}, 8'h01, "shutdown high");
        pd = 1'b0;
        repeat (10) @(negedge clk);
        cmp8({7'h00, shutdown}, 8'h00, "shutdown low");
    endtask

    task automatic t_ident;
        i_host_model.frame(8'h00, 8'h00, 16, rd);
        cmp8(rd, ID_VAL, "id read");
        core_read(7'h05, rd);
        cmp8(rd, 8'h00, "reset value");
    endtask

    // Frames back to back, highest address included
    task automatic t_write_back;
        i_host_model.frame(8'h92, 8'ha5, 16, rd);
        i_host_model.frame(8'h12, 8'h00, 16, rd);
        cmp8(rd, 8'ha5, "readback 12");
        i_host_model.frame(8'hff, 8'h81, 16, rd);
        i_host_model.frame(8'h7f, 8'h00, 16, rd);
        cmp8(rd, 8'h81, "readback 7f");
        cmp8({7'h00, sdio_oe}, 8'h00, "released after read");
        core_read(7'h7f, rd);
        cmp8(rd, 8'h81, "core sees write");
    endtask

    task automatic t_core_wr;
        @(negedge clk) core_wr = {1'b1, 7'h33, 8'h5c};
        @(negedge clk) core_wr = '0;
        repeat (4) @(negedge clk);
        i_host_model.frame(8'h33, 8'h00, 16, rd);
        cmp8(rd, 8'h5c, "core write read");
    endtask

    // Write cut short in its data byte
    task automatic t_abort_write;
        int a0;
        a0 = aborts;
        i_host_model.frame(8'h92, 8'h11, 12, rd);
        @(negedge clk) pd = 1'b1;
        pd_pulse();
        cmp8(8'(aborts - a0), 8'h01, "abort pulse");
        i_host_model.frame(8'h12, 8'h00, 16, rd);
        cmp8(rd, 8'ha5, "kept after abort");
    endtask

    // Read cut short while the sensor drives the line
    task automatic t_abort_read;
        i_host_model.frame(8'h12, 8'h00, 11, rd);
        cmp8({7'h00, sdio_oe}, 8'h01, "driving data");
        @(negedge clk) pd = 1'b1;
        #1;
        cmp8({7'h00, sdio_oe}, 8'h00, "released by pd");
        i_host_model.toggle();
        cmp8({7'h00, sdio_oe}, 8'h00, "released after toggle");
        pd_pulse();
        i_host_model.frame(8'h7f, 8'h00, 16, rd);
        cmp8(rd, 8'h81, "resynced read");
    endtask

    // Full reset in mid-read: line released, registers back to reset
    task automatic t_full_reset;
        i_host_model.frame(8'h12, 8'h00, 11, rd);
        @(negedge clk) rst = 1'b1;
        #1;
        cmp8({7'h00, sdio_oe}, 8'h00, "released by reset");
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        i_host_model.frame(8'h12, 8'h00, 16, rd);
        cmp8(rd, 8'h00, "cleared by reset");
        i_host_model.frame(8'h00, 8'h00, 16, rd);
        cmp8(rd, ID_VAL, "id after reset");
    endtask

    // Reset, then the scenarios in turn
    initial begin
        @(negedge clk) rst = 1'b1;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        t_ident();
        t_write_back();
        t_core_wr();
        t_abort_write();
        t_abort_read();
        t_full_reset();
        finish_test();
    end
endmodule
`default_nettype wire
